//--- logic/lpmc_pkg.sv
package lpmc_pkg;

    // ****************************************************************
    // Mode, state and timing constants
    // ****************************************************************
    localparam int CLK_MHZ = 100;
    localparam int CNT_W   = 13;

    // Mode field values of the low-power control register
    localparam logic MODE_IDLE    = 1'h0;
    localparam logic MODE_STANDBY = 1'h1;

    // Standby drain: system clock kept for at most this many oscillator cycles
    localparam int DRAIN_CYC = 16;

    // Standby wake pulse width with a zero qualify count, and base otherwise
    localparam int STBY_QUAL_ZERO = 3;
    localparam int STBY_QUAL_BASE = 2;

    // Idle wake pulse minimum, and qualify window lengths in sampling periods
    localparam int IDLE_WAKE_MIN  = 2;
    localparam int QUAL_SP_THREE  = 2;
    localparam int QUAL_SP_SIX    = 5;

    // Resume latencies in system clock cycles
    localparam int IDLE_LAT_FLASH = 40;
    localparam int IDLE_LAT_RAM   = 25;
    localparam int STBY_LAT_FLASH = 175;
    localparam int STBY_LAT_RAM   = 18;   // Three oscillator plus fifteen system
    localparam int FLASH_SLEEP_LAT = 6700;

    // Reset values
    localparam logic [5:0] QUAL_STDBY_RST = 6'h00;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        LPMC_RUN,
        LPMC_IDLE,
        LPMC_DRAIN,
        LPMC_STBY,
        LPMC_WAKE,
        LPMC_RESUME
    } lpmc_state_e;

    // Wake sources seen by the controller
    typedef struct packed {
        logic int_pending;   // Any enabled interrupt
        logic watchdog_int;  // Watchdog interrupt
        logic ext_rst;       // External reset pin asserted
        logic ext_wake;      // External wake pin level
        logic cmp_trip;      // Any comparator subsystem trip
    } lpmc_wake_s;

    // Qualifier configuration
    typedef struct packed {
        logic       qual_en;    // Idle wake input qualification enabled
        logic       six_sample; // Six-sample mode when set
        logic [7:0] period;     // Qualify sample period field
    } lpmc_qual_s;

endpackage

//--- logic/lpmc_qual.sv
`timescale 1ns/1ps
// Pulse-width qualifier: output rises once the input has held high for THR cycles
module lpmc_qual #(
    parameter int CNT_W = 13
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             sample_in,
    input  wire logic [CNT_W-1:0] threshold,
    output logic                  qualified
);

    logic [CNT_W-1:0] run_q;
    logic [CNT_W-1:0] run_d;
    logic             sat;

    // Saturate so a long level never wraps back into a false low
    assign sat   = (run_q == {CNT_W{1'b1}});
    assign run_d = !sample_in ? '0 : (sat ? run_q : run_q + 1'b1);

    // Any low sample restarts the count, glitches never qualify
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q     <= '0;
            qualified <= 1'b0;
        end else begin
            run_q     <= run_d;
            qualified <= sample_in && (run_d >= threshold);
        end
    end

endmodule // lpmc_qual

//--- logic/lpmc_top.sv
`timescale 1ns/1ps
// Behaviour
// - Two modes, idle and standby, both entered by the idle instruction.
// - Comparator subsystem trips wake the device from standby.
// - Idle keeps peripheral clocks; standby follows each peripheral's clock config.
// - Watchdog, security, first RAM, ethernet and CAN clocks always run.
// - Idle exits on enabled interrupt, watchdog interrupt or external reset pin.
// - Standby wake pulse minimum: three if count zero, else two plus count.
// - Standby keeps system clock at most sixteen cycles, then stops it.
// - PLL and watchdog keep running in standby; peripheral clocks follow their clock config.
// - Idle resume within 40 flash, 25 RAM, 6700 sleeping flash cycles.
// - Standby resume within 175 flash cycles, or 18 from RAM.
// - After standby the wake interrupt is serviced only if enabled.
// - Qualify window is two or five sampling periods of computed length.
module lpmc_top #(
    parameter int NPER        = 8,
    parameter int FLASH_SLEEP = lpmc_pkg::FLASH_SLEEP_LAT
) (
    input  wire logic                CLK,
    input  wire logic                RSTN,
    input  wire logic                IDLE_EXEC,
    input  wire logic                LP_MODE,
    input  wire logic [5:0]          QUAL_STDBY_CNT,
    input  wire logic [NPER-1:0]     PERIPH_CLK_CFG,
    input  wire lpmc_pkg::lpmc_wake_s WAKE_SRC,
    input  wire lpmc_pkg::lpmc_qual_s QUAL_CFG,
    input  wire logic                WAKE_IRQ_EN,
    input  wire logic                FLASH_SLEEPING,
    input  wire logic                RUN_FROM_RAM,
    output logic                     CPU_CLK_EN,
    output logic                     SYS_CLK_EN,
    output logic [NPER-1:0]          PERIPH_CLK_EN,
    output logic                     AON_CLK_EN,
    output logic                     PLL_EN,
    output logic                     CPU_RESUME,
    output logic                     WAKE_IRQ,
    output logic [2:0]               LP_STATE
);

    // ****************************************************************
    // Parameter checks and reset synchroniser
    // ****************************************************************
    if (NPER < 1 || NPER > 64) begin : g_bad_nper
        $error("NPER out of range");
    end
    if (FLASH_SLEEP < 1 || FLASH_SLEEP >= (1 << lpmc_pkg::CNT_W)) begin : g_bad_fl
        $error("FLASH_SLEEP does not fit the latency counter");
    end

    logic rst_meta_q;
    logic rst_n;

    // Two flops so the release is clean against CLK
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // ****************************************************************
    // Wake qualification
    // ****************************************************************
    localparam int W = lpmc_pkg::CNT_W;

    logic [W-1:0] samp_per;
    logic [W-1:0] win;
    logic [W-1:0] idle_thr;
    logic [W-1:0] stby_thr;
    logic         idle_ext_ok;
    logic         stby_ext_ok;

    // Sampling period is one cycle for zero, twice the field otherwise
    assign samp_per = (QUAL_CFG.period == 8'h00) ? W'(1) : W'({QUAL_CFG.period, 1'b0});
    assign win      = W'(samp_per * W'(QUAL_CFG.six_sample ? lpmc_pkg::QUAL_SP_SIX
                                                          : lpmc_pkg::QUAL_SP_THREE));
    // Idle external wake width, window added when qualified
    assign idle_thr = W'(lpmc_pkg::IDLE_WAKE_MIN) + (QUAL_CFG.qual_en ? win : W'(0));
    // Standby width from the six-bit qualify count
    assign stby_thr = (QUAL_STDBY_CNT == 6'h00) ? W'(lpmc_pkg::STBY_QUAL_ZERO)
                    : W'(lpmc_pkg::STBY_QUAL_BASE) + W'(QUAL_STDBY_CNT);

    // Persistence filter rejects short glitches on the wake pin
    lpmc_qual #(.CNT_W(W)) u_idle_q (
        .clk       (CLK),
        .rst_n     (rst_n),
        .sample_in (WAKE_SRC.ext_wake),
        .threshold (idle_thr),
        .qualified (idle_ext_ok)
    );

    lpmc_qual #(.CNT_W(W)) u_stby_q (
        .clk       (CLK),
        .rst_n     (rst_n),
        .sample_in (WAKE_SRC.ext_wake),
        .threshold (stby_thr),
        .qualified (stby_ext_ok)
    );

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    lpmc_pkg::lpmc_state_e state_q;
    lpmc_pkg::lpmc_state_e state_d;
    logic [W-1:0]          cnt_q;
    logic [W-1:0]          cnt_d;
    logic                  from_stby_q;
    logic                  from_stby_d;
    logic                  idle_wake;
    logic                  stby_wake;
    logic [W-1:0]          lat;

    // Idle wakes on enabled interrupt, watchdog, reset pin or qualified pin
    assign idle_wake = WAKE_SRC.int_pending | WAKE_SRC.watchdog_int
                     | WAKE_SRC.ext_rst | idle_ext_ok;
    // Standby wakes on qualified pin, comparator trip or reset pin
    assign stby_wake = stby_ext_ok | WAKE_SRC.cmp_trip | WAKE_SRC.ext_rst;

    // Resume latency chosen from the memory the CPU returns to
    assign lat = FLASH_SLEEPING ? W'(FLASH_SLEEP)
               : from_stby_d ? (RUN_FROM_RAM ? W'(lpmc_pkg::STBY_LAT_RAM)
                                             : W'(lpmc_pkg::STBY_LAT_FLASH))
               : (RUN_FROM_RAM ? W'(lpmc_pkg::IDLE_LAT_RAM)
                               : W'(lpmc_pkg::IDLE_LAT_FLASH));

    // Next state; the wake source keeps its own entry spacing
    always_comb begin
        state_d     = state_q;
        cnt_d       = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
        from_stby_d = from_stby_q;
        case (state_q)
            lpmc_pkg::LPMC_RUN: begin
                if (IDLE_EXEC) begin
                    // Mode sampled only as the idle instruction executes
                    from_stby_d = (LP_MODE == lpmc_pkg::MODE_STANDBY);
                    if (LP_MODE == lpmc_pkg::MODE_STANDBY) begin
                        state_d = lpmc_pkg::LPMC_DRAIN;
                        cnt_d   = W'(lpmc_pkg::DRAIN_CYC - 1);
                    end else begin
                        state_d = lpmc_pkg::LPMC_IDLE;
                    end
                end
            end
            lpmc_pkg::LPMC_IDLE: begin
                if (idle_wake) begin
                    state_d = lpmc_pkg::LPMC_WAKE;
                    cnt_d   = lat - 1'b1;
                end
            end
            lpmc_pkg::LPMC_DRAIN: begin
                // Pipeline flush window, then system clock stops
                if (cnt_q == '0) begin
                    state_d = lpmc_pkg::LPMC_STBY;
                end
            end
            lpmc_pkg::LPMC_STBY: begin
                if (stby_wake) begin
                    state_d = lpmc_pkg::LPMC_WAKE;
                    cnt_d   = lat - 1'b1;
                end
            end
            lpmc_pkg::LPMC_WAKE: begin
                if (cnt_q == '0) begin
                    state_d = lpmc_pkg::LPMC_RESUME;
                end
            end
            lpmc_pkg::LPMC_RESUME: begin
                state_d = lpmc_pkg::LPMC_RUN;
            end
            default: begin
                state_d = lpmc_pkg::LPMC_RUN;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= lpmc_pkg::LPMC_RUN;
            cnt_q       <= '0;
            from_stby_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            from_stby_q <= from_stby_d;
        end
    end

    // ****************************************************************
    // Clock enables and CPU release, all registered
    // ****************************************************************
    logic            stby_d;
    logic            cpu_gate_d;
    logic [NPER-1:0] per_d;

    assign stby_d     = (state_d == lpmc_pkg::LPMC_STBY);
    // CPU clock stays until drain ends; idle keeps it
    assign cpu_gate_d = stby_d;
    // Peripherals run in idle, follow config in standby
    assign per_d      = stby_d ? PERIPH_CLK_CFG : {NPER{1'b1}};

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            CPU_CLK_EN    <= 1'b1;
            SYS_CLK_EN    <= 1'b1;
            PERIPH_CLK_EN <= {NPER{1'b1}};
            AON_CLK_EN    <= 1'b1;
            PLL_EN        <= 1'b1;
            CPU_RESUME    <= 1'b0;
            WAKE_IRQ      <= 1'b0;
            LP_STATE      <= 3'h0;
        end else begin
            CPU_CLK_EN    <= !cpu_gate_d;
            SYS_CLK_EN    <= !stby_d;
            PERIPH_CLK_EN <= per_d;
            AON_CLK_EN    <= 1'b1;
            PLL_EN        <= 1'b1;
            CPU_RESUME    <= (state_d == lpmc_pkg::LPMC_RESUME);
            WAKE_IRQ      <= (state_d == lpmc_pkg::LPMC_RESUME)
                             && WAKE_IRQ_EN;
            LP_STATE      <= state_d;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // Drain length kept in helper logic; a long repetition would unroll badly
    logic [4:0] drain_seen_q;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) drain_seen_q <= 5'h00;
        else drain_seen_q <= (state_q == lpmc_pkg::LPMC_DRAIN) ? drain_seen_q + 5'h01 : 5'h00;
    end

    property p_drain_len;
        @(posedge CLK) disable iff (!rst_n)
        $fell(state_q == lpmc_pkg::LPMC_DRAIN) |-> state_q == lpmc_pkg::LPMC_STBY
            && !SYS_CLK_EN && drain_seen_q == 5'(lpmc_pkg::DRAIN_CYC);
    endproperty
    a_drain_len: assert property (p_drain_len) else $error("drain not 16 cycles");

    property p_drain_clk;
        @(posedge CLK) disable iff (!rst_n)
        state_q == lpmc_pkg::LPMC_DRAIN |->
            SYS_CLK_EN && drain_seen_q < 5'(lpmc_pkg::DRAIN_CYC);
    endproperty
    a_drain_clk: assert property (p_drain_clk) else $error("drain clock wrong");

    property p_idle_clocks;
        @(posedge CLK) disable iff (!rst_n)
        state_q == lpmc_pkg::LPMC_IDLE |->
            SYS_CLK_EN && CPU_CLK_EN && (PERIPH_CLK_EN == {NPER{1'b1}});
    endproperty
    a_idle_clocks: assert property (p_idle_clocks) else $error("idle gated a clock");

    property p_stby_periph;
        @(posedge CLK) disable iff (!rst_n)
        state_q == lpmc_pkg::LPMC_STBY && $stable(PERIPH_CLK_CFG) && $past(state_q)
            == lpmc_pkg::LPMC_STBY |-> PERIPH_CLK_EN == PERIPH_CLK_CFG && !CPU_CLK_EN;
    endproperty
    a_stby_periph: assert property (p_stby_periph) else $error("standby gating wrong");

    property p_aon;
        @(posedge CLK) disable iff (!rst_n)
        state_q == lpmc_pkg::LPMC_STBY |-> AON_CLK_EN && PLL_EN;
    endproperty
    a_aon: assert property (p_aon) else $error("always-on clock stopped");

    property p_idle_wake;
        @(posedge CLK) disable iff (!rst_n)
        state_q == lpmc_pkg::LPMC_IDLE && (WAKE_SRC.watchdog_int || WAKE_SRC.int_pending
            || WAKE_SRC.ext_rst) |=> state_q == lpmc_pkg::LPMC_WAKE;
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle missed wake");

    property p_cmp_wake;
        @(posedge CLK) disable iff (!rst_n)
        state_q == lpmc_pkg::LPMC_STBY && WAKE_SRC.cmp_trip |=>
            state_q == lpmc_pkg::LPMC_WAKE;
    endproperty
    a_cmp_wake: assert property (p_cmp_wake) else $error("trip did not wake");

    property p_stby_qual;
        @(posedge CLK) disable iff (!rst_n)
        state_q == lpmc_pkg::LPMC_STBY && !WAKE_SRC.cmp_trip && !WAKE_SRC.ext_rst
            && QUAL_STDBY_CNT == 6'h00 && $past(QUAL_STDBY_CNT) == 6'h00
            && !$past(WAKE_SRC.ext_wake, 3) |=> state_q != lpmc_pkg::LPMC_WAKE;
    endproperty
    a_stby_qual: assert property (p_stby_qual) else $error("short pulse woke");

    property p_ram_idle_lat;
        @(posedge CLK) disable iff (!rst_n)
        $rose(state_q == lpmc_pkg::LPMC_WAKE) && !from_stby_q && $past(RUN_FROM_RAM)
            && !$past(FLASH_SLEEPING) |-> ##25 CPU_RESUME;
    endproperty
    a_ram_idle_lat: assert property (p_ram_idle_lat) else $error("idle RAM latency");

    property p_flash_stby_lat;
        @(posedge CLK) disable iff (!rst_n)
        $rose(state_q == lpmc_pkg::LPMC_WAKE) && from_stby_q && !$past(RUN_FROM_RAM)
            && !$past(FLASH_SLEEPING) |-> ##[1:175] CPU_RESUME;
    endproperty
    a_flash_stby_lat: assert property (p_flash_stby_lat) else $error("standby latency");

    property p_irq_gate;
        @(posedge CLK) disable iff (!rst_n)
        WAKE_IRQ |-> CPU_RESUME && $past(WAKE_IRQ_EN);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");

    property p_mode_pick;
        @(posedge CLK) disable iff (!rst_n)
        state_q == lpmc_pkg::LPMC_RUN && IDLE_EXEC |=>
            state_q == (LP_MODE ? lpmc_pkg::LPMC_DRAIN : lpmc_pkg::LPMC_IDLE);
    endproperty
    a_mode_pick: assert property (p_mode_pick) else $error("wrong mode taken");

    property p_resume_run;
        @(posedge CLK) disable iff (!rst_n)
        CPU_RESUME |-> CPU_CLK_EN && SYS_CLK_EN ##1 !CPU_RESUME;
    endproperty
    a_resume_run: assert property (p_resume_run) else $error("resume not clean");

    c_idle_trip: cover property (@(posedge CLK) disable iff (!rst_n)
        state_q == lpmc_pkg::LPMC_IDLE ##[1:50] CPU_RESUME);
    c_stby_trip: cover property (@(posedge CLK) disable iff (!rst_n)
        state_q == lpmc_pkg::LPMC_STBY ##[1:300] CPU_RESUME);
    c_irq: cover property (@(posedge CLK) disable iff (!rst_n) WAKE_IRQ);

endmodule // lpmc_top

//--- testbench/lpmc_partner.sv
`timescale 1ns/1ps
// ****************************************************************
// CPU core and wake sources seen from outside the controller
// ****************************************************************
module lpmc_partner (
    input  wire logic            clk,
    output logic                 idle_exec,
    output logic                 lp_mode,
    output lpmc_pkg::lpmc_wake_s wake
);
    int since_q;

    // Quiet lines until the bench asks for something
    initial begin
        idle_exec = 1'h0;
        lp_mode = 1'h0;
        wake = '0;
        since_q = 0;
    end

    // Cycles since the last idle instruction
    always @(posedge clk) begin
        since_q <= idle_exec ? 0 : since_q + 1;
    end

    // One-cycle idle instruction with the mode field beside it
    task automatic enter(input logic m);
        @(posedge clk);
        idle_exec <= 1'h1;
        lp_mode <= m;
        @(posedge clk);
        idle_exec <= 1'h0;
    endtask

    // Clean level, held until the bench drops it
    task automatic wake_on(input int k);
        while (since_q < 5) @(posedge clk);
        @(posedge clk);
        wake <= lpmc_pkg::lpmc_wake_s'(5'h01 << k);
    endtask

    task automatic wake_off();
        @(posedge clk);
        wake <= '0;
    endtask

    // Glitch-free pulse of exactly w cycles
    task automatic pulse(input int k, input int w);
        wake_on(k);
        repeat (w - 1) @(posedge clk);
        wake_off();
    endtask
endmodule // lpmc_partner

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb;
    localparam int NPER = 8;
    localparam int FSL  = 50;   // Short flash wake keeps the run brief

    logic                 CLK, RSTN, IDLE_EXEC, LP_MODE, WAKE_IRQ_EN;
    logic                 FLASH_SLEEPING, RUN_FROM_RAM;
    logic [5:0]           QUAL_STDBY_CNT;
    logic [NPER-1:0]      PERIPH_CLK_CFG, PERIPH_CLK_EN;
    lpmc_pkg::lpmc_wake_s WAKE_SRC;
    lpmc_pkg::lpmc_qual_s QUAL_CFG;
    logic                 CPU_CLK_EN, SYS_CLK_EN, AON_CLK_EN, PLL_EN, CPU_RESUME, WAKE_IRQ;
    logic [2:0]           LP_STATE;
    int                   seed = 60750;
    int                   fails = 0;
    int                   cmp_count = 0;
    int                   cyc = 0;

    lpmc_top #(.NPER(NPER), .FLASH_SLEEP(FSL)) dut (
        .CLK(CLK), .RSTN(RSTN), .IDLE_EXEC(IDLE_EXEC), .LP_MODE(LP_MODE),
        .QUAL_STDBY_CNT(QUAL_STDBY_CNT), .PERIPH_CLK_CFG(PERIPH_CLK_CFG),
        .WAKE_SRC(WAKE_SRC), .QUAL_CFG(QUAL_CFG), .WAKE_IRQ_EN(WAKE_IRQ_EN),
        .FLASH_SLEEPING(FLASH_SLEEPING), .RUN_FROM_RAM(RUN_FROM_RAM),
        .CPU_CLK_EN(CPU_CLK_EN), .SYS_CLK_EN(SYS_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN),
        .AON_CLK_EN(AON_CLK_EN), .PLL_EN(PLL_EN), .CPU_RESUME(CPU_RESUME),
        .WAKE_IRQ(WAKE_IRQ), .LP_STATE(LP_STATE));

    lpmc_partner cpu (.clk(CLK), .idle_exec(IDLE_EXEC), .lp_mode(LP_MODE), .wake(WAKE_SRC));

    // ****************************************************************
    // Expectations and comparisons
    // ****************************************************************
    function automatic int lat(input logic m, input logic fs, input logic ram);
        if (fs) return FSL;
        if (m) return ram ? lpmc_pkg::STBY_LAT_RAM : 175;
        return ram ? 25 : 40;
    endfunction

    // Wake pulse needed before the controller may take it
    function automatic int thr(input logic m, input lpmc_pkg::lpmc_qual_s q,
                               input logic [5:0] c);
        int sp;
        if (m) return (c == 6'h00) ? 3 : 2 + int'(c);
        sp = (q.period == 8'h00) ? 1 : 2 * int'(q.period);
        return 2 + (q.qual_en ? sp * (q.six_sample ? 5 : 2) : 0);
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        cmp_count++;
        if (got < lo || got > hi) begin
            fails++;
            $display("Error %s expected %0d to %0d seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ****************************************************************
    // One entry, wake and resume; k indexes the wake struct bit
    // ****************************************************************
    task automatic op(input logic m, input int k, input logic fs, input logic ram,
                      input logic ien);
        int n;
        int t;
        @(posedge CLK);
        FLASH_SLEEPING <= fs;
        RUN_FROM_RAM <= ram;
        WAKE_IRQ_EN <= ien;
        PERIPH_CLK_CFG <= NPER'($random(seed));
        QUAL_STDBY_CNT <= 6'($random(seed));
        QUAL_CFG <= {1'($random(seed)), 1'($random(seed)), 8'($random(seed) & 3)};
        @(posedge CLK);
        #1;
        t = thr(m, QUAL_CFG, QUAL_STDBY_CNT);
        cpu.enter(m);
        #1;
        chk("entry state", m ? 3'h2 : 3'h1, LP_STATE);
        chk("always-on", 2'h3, {AON_CLK_EN, PLL_EN});
        if (m) begin
            n = 1;
            while (LP_STATE === 3'h2 && n < 40) begin
                @(posedge CLK);
                #1;
                if (LP_STATE === 3'h2) n++;
            end
            chk("drain cycles", 16, n);
            chk("standby state", 3'h3, LP_STATE);
            chk("stby clocks", 4'h3, {SYS_CLK_EN, CPU_CLK_EN, AON_CLK_EN, PLL_EN});
            chk("periph standby", PERIPH_CLK_CFG, PERIPH_CLK_EN);
            cpu.pulse(4, 3);
            repeat (3) @(posedge CLK);
            #1;
            chk("irq ignored standby", 3'h3, LP_STATE);
        end else begin
            chk("idle clocks", {NPER{1'h1}}, PERIPH_CLK_EN);
            chk("idle cpu sys", 2'h3, {CPU_CLK_EN, SYS_CLK_EN});
        end
        // A pulse one cycle short must be refused
        if (k == 1) begin
            cpu.pulse(1, t - 1);
            repeat (3) @(posedge CLK);
            #1;
            chk("short pulse", m ? 3'h3 : 3'h1, LP_STATE);
        end
        cpu.wake_on(k);
        #1;
        n = 0;
        while (LP_STATE !== 3'h4 && n < 100) begin
            @(posedge CLK);
            #1;
            n++;
        end
        if (k == 1) chk_rng("wake delay", t, t + 3, n);
        else chk("wake delay", 1, n);
        chk("wake clocks", {(NPER+2){1'h1}}, {PERIPH_CLK_EN, SYS_CLK_EN, CPU_CLK_EN});
        cpu.wake_off();
        #1;
        n = 1;
        while (CPU_RESUME !== 1'h1 && n < 400) begin
            @(posedge CLK);
            #1;
            n++;
        end
        chk("resume latency", lat(m, fs, ram), n);
        chk("resume state irq", {3'h5, ien}, {LP_STATE, WAKE_IRQ});
        @(posedge CLK);
        #1;
        chk("after resume", 4'h0, {LP_STATE, CPU_RESUME});
    endtask

    // ****************************************************************
    // Clock, timeout and main sequence
    // ****************************************************************
    initial begin
        CLK = 1'h0;
        forever #5 CLK = ~CLK;
    end

    // Hang guard, well above the longest expected run
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            final_report();
        end
    end

    initial begin
        logic m;
        int   k;
        RSTN = 1'h0;
        WAKE_IRQ_EN = 1'h0;
        FLASH_SLEEPING = 1'h0;
        RUN_FROM_RAM = 1'h0;
        QUAL_STDBY_CNT = 6'h00;
        PERIPH_CLK_CFG = '0;
        QUAL_CFG = '0;
        repeat (2) @(posedge CLK);
        RSTN <= 1'h1;
        repeat (5) @(posedge CLK);
        // Every wake source of each mode, then random mixes
        for (int j = 1; j <= 4; j++) op(1'h0, j, j == 4, j[0], j[1]);
        for (int j = 0; j <= 2; j++) op(1'h1, j, j == 2, j[0], 1'h1);
        for (int i = 0; i < 24; i++) begin
            m = 1'($random(seed));
            k = m ? int'($unsigned($random(seed)) % 3) : 1 + int'($unsigned($random(seed)) % 4);
            op(m, k, ($random(seed) & 7) == 0, 1'($random(seed)), 1'($random(seed)));
        end
        // Reset in mid-idle restores running clocks at once
        cpu.enter(1'h0);
        @(posedge CLK);
        RSTN <= 1'h0;
        #1;
        chk("reset state", 5'h00, {LP_STATE, CPU_RESUME, WAKE_IRQ});
        chk("reset clocks", 2'h3, {CPU_CLK_EN, SYS_CLK_EN});
        repeat (2) @(posedge CLK);
        RSTN <= 1'h1;
        repeat (5) @(posedge CLK);
        op(1'h0, 4, 1'h0, 1'h1, 1'h1);
        final_report();
    end
endmodule // tb
